// ==== hdl/pmt_timer.sv ====
// Purpose : Eight-bit period match timer with prescaler and postscaler.
// Assumes : aclk is the oscillator; instruction clock is a quarter of it.
// Notes   : Match pulse feeds capture/compare, serial port and gates.
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////
module pmt_timer (
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    input  wire logic [pmt_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [pmt_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [31:0]                     s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    output logic                            match_to_capture,
    output logic                            match_to_serial,
    output logic                            reload_to_gate,
    output logic                            irq
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    pmt_pkg::pmt_core_t state;      // Registered core state
    pmt_pkg::pmt_core_t next_state; // Next core state

    logic [pmt_pkg::ADDR_W-1:0] wr_addr; // Held write address
    logic [7:0]                 wr_data; // Held write byte
    logic                       wr_en;   // One-cycle write strobe
    logic                       wr_hit;  // Write address is mapped
    logic [7:0]                 rd_data; // Read mux result
    logic                       rd_hit;  // Read address is mapped
    logic                       instr_tick; // Instruction clock enable
    logic                       timer_tick; // Prescaled counting enable
    logic                       scaler_clr; // Clear both scalers
    logic                       run;        // Timer on bit
    logic [1:0]                 ps_sel;     // Prescale select field
    logic [3:0]                 post_sel;   // Postscale select field
    logic                       post_done;  // Postscaler completes

    ////////////////////////////////////////////////////////////////////////
    // Helper functions

    // Byte address to register index, low two bits ignored
    function automatic logic [15:0] addr_idx(
        input logic [pmt_pkg::ADDR_W-1:0] a
    );
        addr_idx = 16'({2'b00, a[pmt_pkg::ADDR_W-1:2]});
    endfunction : addr_idx

    // True where an index names one of our registers
    function automatic logic idx_mapped(input logic [15:0] i);
        idx_mapped = (i == pmt_pkg::IDX_CONTROL) ||
                     (i == pmt_pkg::IDX_COUNT)   ||
                     (i == pmt_pkg::IDX_LIMIT)   ||
                     (i == pmt_pkg::IDX_FLAG)    ||
                     (i == pmt_pkg::IDX_ENABLE);
    endfunction : idx_mapped

    // Last prescaler count for a select code
    function automatic logic [3:0] pre_last(input logic [1:0] sel);
        case (sel)
            2'h0:    pre_last = pmt_pkg::PRE_DIV1;
            2'h1:    pre_last = pmt_pkg::PRE_DIV4;
            default: pre_last = pmt_pkg::PRE_DIV16;
        endcase
    endfunction : pre_last

    ////////////////////////////////////////////////////////////////////////
    // Bus front end

    // Slave handles channel order and answers
    pmt_axil u_axil (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_en         (wr_en),
        .wr_addr       (wr_addr),
        .wr_data       (wr_data),
        .wr_hit        (wr_hit),
        .rd_data       (rd_data),
        .rd_hit        (rd_hit)
    );

    // Address decode for both directions
    assign wr_hit = idx_mapped(addr_idx(wr_addr));
    assign rd_hit = idx_mapped(addr_idx(s_axi_araddr));

    // Read mux; control bit 7 and unused flag bits read zero
    always_comb begin
        case (addr_idx(s_axi_araddr))
            pmt_pkg::IDX_CONTROL: begin
                rd_data = {1'b0, state.ctrl};
            end
            pmt_pkg::IDX_COUNT: begin
                rd_data = state.count;
            end
            pmt_pkg::IDX_LIMIT: begin
                rd_data = state.limit;
            end
            pmt_pkg::IDX_FLAG: begin
                rd_data = 8'(state.flag) << pmt_pkg::FLAG_POS;
            end
            pmt_pkg::IDX_ENABLE: begin
                rd_data = 8'(state.ien) << pmt_pkg::FLAG_POS;
            end
            default: begin
                rd_data = 8'h00; // Unmapped reads zero
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Control fields and clock enables

    // Control fields as stored
    assign run      = state.ctrl[pmt_pkg::RUN_POS];
    assign ps_sel   = state.ctrl[pmt_pkg::PS_POS +: 2];
    assign post_sel = state.ctrl[pmt_pkg::POST_POS +: 4];

    // Writes to count or control restart both scalers
    assign scaler_clr = wr_en &&
        ((addr_idx(wr_addr) == pmt_pkg::IDX_COUNT) ||
         (addr_idx(wr_addr) == pmt_pkg::IDX_CONTROL));

    // Instruction clock: one aclk in four, free running
    pmt_divider #(
        .W (2)
    ) u_instr (
        .aclk    (aclk),
        .aresetn (aresetn),
        .en_in   (1'b1),
        .clear   (1'b0),
        .last    (2'(pmt_pkg::OSC_DIV - 1)),
        .tick    (instr_tick)
    );

    // Prescaler; only advances while the timer is on,
    // so an idle timer leaves all but the instruction clock quiet
    pmt_divider #(
        .W (4)
    ) u_pre (
        .aclk    (aclk),
        .aresetn (aresetn),
        .en_in   (instr_tick && run),
        .clear   (scaler_clr),
        .last    (pre_last(ps_sel)),
        .tick    (timer_tick)
    );

    // Postscaler completes when its count reaches the select code
    assign post_done = (state.post == post_sel);

    ////////////////////////////////////////////////////////////////////////
    // Core next-state logic

    always_comb begin
        next_state        = state;
        next_state.match  = 1'b0;
        next_state.reload = 1'b0;

        // Counting and match; compare runs on each timer tick
        if (timer_tick) begin
            if (state.count == state.limit) begin
                // Reload on the increment after the match
                next_state.count  = 8'h00;
                next_state.match  = 1'b1;
                next_state.reload = 1'b1;
                // Step postscaler, flag on its last count
                if (post_done) begin
                    next_state.post = 4'h0;
                    next_state.flag = 1'b1;
                end else begin
                    next_state.post = state.post + 4'h1;
                end
            end else begin
                next_state.count = state.count + 8'h01;
            end
        end

        // A scaler clear restarts the postscaler count
        if (scaler_clr) begin
            next_state.post = 4'h0;
        end

        // Register writes; a counter write beats a tick
        if (wr_en) begin
            case (addr_idx(wr_addr))
                pmt_pkg::IDX_CONTROL: begin
                    // Counter left alone on purpose
                    next_state.ctrl = wr_data[6:0];
                end
                pmt_pkg::IDX_COUNT: begin
                    next_state.count = wr_data;
                end
                pmt_pkg::IDX_LIMIT: begin
                    next_state.limit = wr_data;
                end
                pmt_pkg::IDX_FLAG: begin
                    // Write one clears; a new event in the
                    // same cycle wins over the clear
                    if (wr_data[pmt_pkg::FLAG_POS] &&
                        !(timer_tick && post_done &&
                          state.count == state.limit)) begin
                        next_state.flag = 1'b0;
                    end
                end
                pmt_pkg::IDX_ENABLE: begin
                    next_state.ien = wr_data[pmt_pkg::FLAG_POS];
                end
                default: begin
                    next_state.ctrl = state.ctrl; // Unmapped: no effect
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    // Synchronous reset: counter zero, period all ones
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state.count  <= pmt_pkg::COUNT_RST;
            state.limit  <= pmt_pkg::LIMIT_RST;
            state.ctrl   <= pmt_pkg::CTRL_RST;
            state.post   <= 4'h0;
            state.flag   <= 1'b0;
            state.ien    <= 1'b0;
            state.match  <= 1'b0;
            state.reload <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    // Unscaled match time base for capture/compare PWM
    assign match_to_capture = state.match;
    // Same pulse offered as serial port shift clock source
    assign match_to_serial  = state.match;
    // Reload pulse to the gate logic of other timers
    assign reload_to_gate   = state.reload;
    // Level interrupt while flag set and enabled
    assign irq = state.flag && state.ien;

endmodule : pmt_timer

// ==== hdl/pmt_pkg.sv ====
// Purpose : Shared constants and state types of the period match timer.
// Assumes : 32-bit AXI4-Lite register bus, one aligned word per register.
// Notes   : Byte address of a register is four times its index.
package pmt_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register indices and byte address width
    localparam logic [15:0] IDX_CONTROL = 16'h0FCA; // Control register
    localparam logic [15:0] IDX_COUNT   = 16'h0FCB; // Live counter
    localparam logic [15:0] IDX_LIMIT   = 16'h0FCC; // Period register
    localparam logic [15:0] IDX_FLAG    = 16'h0FCD; // Sticky match flag
    localparam logic [15:0] IDX_ENABLE  = 16'h0FCE; // Interrupt mask
    localparam int          ADDR_W      = 16;       // Byte address width

    ////////////////////////////////////////////////////////////////////////
    // Control field layout
    localparam int PS_POS   = 0; // Input prescale select, two bits
    localparam int RUN_POS  = 2; // Timer on
    localparam int POST_POS = 3; // Postscale select, four bits
    localparam int FLAG_POS = 1; // Match flag in flag and enable regs

    ////////////////////////////////////////////////////////////////////////
    // Reset values and timing counts
    localparam logic [7:0] COUNT_RST  = 8'h00; // Counter after reset
    localparam logic [7:0] LIMIT_RST  = 8'hFF; // Period after reset
    localparam logic [6:0] CTRL_RST   = 7'h00; // Control after reset
    localparam logic [3:0] PRE_DIV1   = 4'h0;  // Prescale 1:1 last count
    localparam logic [3:0] PRE_DIV4   = 4'h3;  // Prescale 1:4 last count
    localparam logic [3:0] PRE_DIV16  = 4'hF;  // Prescale 1:16 last count
    localparam int         OSC_DIV    = 4;     // Instruction clock ratio
    localparam logic [1:0] RESP_OKAY  = 2'h0;  // AXI answer: done
    localparam logic [1:0] RESP_SLV   = 2'h2;  // AXI answer: unmapped

    ////////////////////////////////////////////////////////////////////////
    // State of the timer core
    typedef struct packed {
        logic [7:0] count;  // Counter value
        logic [7:0] limit;  // Period value
        logic [6:0] ctrl;   // Control bits 6..0
        logic [3:0] post;   // Postscaler count
        logic       flag;   // Sticky match flag
        logic       ien;    // Match interrupt enable
        logic       match;  // One-cycle match pulse
        logic       reload; // One-cycle reload pulse
    } pmt_core_t;

endpackage : pmt_pkg

// ==== hdl/pmt_divider.sv ====
// Purpose : Counting divider giving a one-cycle enable pulse.
// Assumes : Counts only on cycles where en_in is high.
// Notes   : Tick is combinational so the caller sees it in the same cycle.
`timescale 1ns/1ns
module pmt_divider #(
    parameter int W = 4 // Counter width
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         en_in,
    input  wire logic         clear,
    input  wire logic [W-1:0] last,
    output logic              tick
);
    typedef struct packed {
        logic [W-1:0] cnt; // Current count
    } pmt_div_t;

    pmt_div_t state;      // Registered state
    pmt_div_t next_state; // Next state

    // Refuse a width the count cannot hold
    if (W < 1) begin : g_chk
        $error("pmt_divider width must be at least one");
    end

    // Tick on the last count of a period
    assign tick = en_in && (state.cnt == last) && !clear;

    // Next count: clear wins, wrap at last
    always_comb begin
        next_state = state;
        if (clear) begin
            next_state.cnt = '0;
        end else if (tick) begin
            next_state.cnt = '0;
        end else if (en_in) begin
            next_state.cnt = state.cnt + W'(1);
        end
    end

    // Synchronous active-low reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

endmodule : pmt_divider

// ==== hdl/pmt_axil.sv ====
// Purpose : AXI4-Lite slave front end for the timer registers.
// Assumes : One write and one read outstanding at most.
// Notes   : Write issues one-cycle wr_en once address and data are held, if mapped and lane 0 strobed.
`timescale 1ns/1ns
module pmt_axil (
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    input  wire logic [pmt_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [pmt_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [31:0]                     s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    output logic                            wr_en,
    output logic [pmt_pkg::ADDR_W-1:0]      wr_addr,
    output logic [7:0]                      wr_data,
    input  wire logic                       wr_hit,
    input  wire logic [7:0]                 rd_data,
    input  wire logic                       rd_hit
);
    typedef struct packed {
        logic                       aw_full; // Address held
        logic [pmt_pkg::ADDR_W-1:0] awaddr;
        logic                       w_full;  // Data held
        logic [7:0]                 wdata;
        logic                       wlane;   // Byte lane 0 strobed
        logic                       bvalid;
        logic [1:0]                 bresp;
        logic                       rvalid;
        logic [1:0]                 rresp;
        logic [7:0]                 rdata;
    } pmt_axil_t;

    pmt_axil_t state;      // Registered state
    pmt_axil_t next_state; // Next state

    // Channels open while nothing waits behind them
    assign s_axi_awready = !state.aw_full && !state.bvalid;
    assign s_axi_wready  = !state.w_full && !state.bvalid;
    assign s_axi_arready = !state.rvalid;
    assign s_axi_bvalid  = state.bvalid;
    assign s_axi_bresp   = state.bresp;
    assign s_axi_rvalid  = state.rvalid;
    assign s_axi_rresp   = state.rresp;
    assign s_axi_rdata   = {24'h000000, state.rdata};
    // Register file sees the held write address and data
    assign wr_addr = state.awaddr;
    assign wr_data = state.wdata;
    // Only lane 0 holds data; other lanes alone change nothing
    assign wr_en   = state.aw_full && state.w_full && state.wlane && wr_hit;

    // Channel bookkeeping
    always_comb begin
        next_state = state;
        if (s_axi_awvalid && s_axi_awready) begin
            next_state.aw_full = 1'b1;
            next_state.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_state.w_full = 1'b1;
            next_state.wdata  = s_axi_wdata[7:0];
            next_state.wlane  = s_axi_wstrb[0];
        end
        if (state.aw_full && state.w_full) begin
            next_state.aw_full = 1'b0;
            next_state.w_full  = 1'b0;
            next_state.bvalid  = 1'b1;
            next_state.bresp   = wr_hit ? pmt_pkg::RESP_OKAY
                                        : pmt_pkg::RESP_SLV;
        end
        if (state.bvalid && s_axi_bready) begin
            next_state.bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_state.rvalid = 1'b1;
            next_state.rdata  = rd_hit ? rd_data : 8'h00;
            next_state.rresp  = rd_hit ? pmt_pkg::RESP_OKAY
                                       : pmt_pkg::RESP_SLV;
        end else if (state.rvalid && s_axi_rready) begin
            next_state.rvalid = 1'b0;
        end
    end

    // Synchronous active-low reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

endmodule : pmt_axil

// ==== sim/pmt_timer_sva.sv ====
// Purpose : Port-level assertions for the period match timer.
// Assumes : One clock domain, synchronous active-low reset.
// Notes   : Bound below to every pmt_timer instance.
`timescale 1ns/1ns
module pmt_timer_sva (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        s_axi_bvalid,
    input  wire logic        s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        match_to_capture,
    input  wire logic        match_to_serial,
    input  wire logic        reload_to_gate,
    input  wire logic        irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////
    // All match taps are the one unscaled pulse
    property p_serial; match_to_serial == match_to_capture; endproperty
    a_serial: assert property (p_serial) else $error("serial tap");
    property p_gate; reload_to_gate == match_to_capture; endproperty
    a_gate: assert property (p_gate) else $error("gate tap");
    // Ticks come at most one aclk in four
    property p_gap; match_to_capture |=> !match_to_capture [*3]; endproperty
    a_gap: assert property (p_gap) else $error("match too soon");
    // Interrupt only rises on a match or a register write
    property p_irq_up;
        $rose(irq) |-> match_to_capture || $past(match_to_capture)
            || $rose(s_axi_bvalid);
    endproperty
    a_irq_up: assert property (p_irq_up) else $error("irq rose");
    // Sticky: only software lowers it
    property p_irq_dn; $fell(irq) |-> $rose(s_axi_bvalid); endproperty
    a_irq_dn: assert property (p_irq_dn) else $error("irq fell");
    ////////////////////////////////////////////////////////////////////////
    // Register reads; covers of match and interrupt edges
    property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rans: assert property (p_rans) else $error("no read answer");
    property p_rhold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read dropped");
    property p_rtop; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
    endproperty
    a_rtop: assert property (p_rtop) else $error("upper bits set");
    c_match: cover property (match_to_capture);
    c_irq_up: cover property ($rose(irq));
    c_irq_dn: cover property ($fell(irq));
endmodule : pmt_timer_sva

bind pmt_timer pmt_timer_sva u_sva (
    .aclk, .aresetn, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .match_to_capture,
    .match_to_serial, .reload_to_gate, .irq
);

// ==== sim/pmt_timer_test.sv ====
// Purpose : Self-checking bench of the period match timer.
// Assumes : Inputs change by non-blocking assignment at rising edges.
// Notes   : Timer is stopped before the flag is touched.
`timescale 1ns/1ns
module pmt_timer_test;
    localparam logic [15:0] A_CTL = pmt_pkg::IDX_CONTROL << 2;
    localparam logic [15:0] A_CNT = pmt_pkg::IDX_COUNT << 2;
    localparam logic [15:0] A_LIM = pmt_pkg::IDX_LIMIT << 2;
    localparam logic [15:0] A_FLG = pmt_pkg::IDX_FLAG << 2;
    localparam logic [15:0] A_ENA = pmt_pkg::IDX_ENABLE << 2;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic        match_to_capture, match_to_serial, reload_to_gate;
    logic [15:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    int          n_errors, checks_done;
    pmt_timer dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .match_to_capture,
        .match_to_serial, .reload_to_gate, .irq);
    ////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic chk(input string nm, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Write: address and data offered together, each dropped when taken
    task automatic wr(input logic [15:0] a, input logic [7:0] d,
                      input logic [1:0] er = pmt_pkg::RESP_OKAY);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        chk("write_wait", 32'h0, {31'h0, n >= 40});
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask : wr
    // Read: ready raised late so the answer must stand a cycle
    task automatic rd(input logic [15:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            // Answer taken at the edge where both are high
            if (s_axi_rvalid && s_axi_rready) break;
            if (s_axi_rvalid) s_axi_rready <= 1'b1;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        chk("read_wait", 32'h0, {31'h0, n >= 40});
    endtask : rd
    task automatic rchk(input logic [15:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        chk("rdata", e, d);
    endtask : rchk
    task automatic wait_match(output int c);
        c = 0;
        do begin
            @(posedge aclk);
            c++;
        end while (match_to_capture !== 1'b1 && c < 400);
    endtask : wait_match
    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_regs;
        logic [31:0] d;
        logic [1:0]  r;
        rchk(A_CNT, 32'h00);
        rchk(A_LIM, 32'hFF);
        rd(16'h0010, d, r);
        chk("rresp", {30'h0, pmt_pkg::RESP_SLV}, {30'h0, r});
        wr(16'h0010, 8'h11, pmt_pkg::RESP_SLV);
        wr(A_LIM, 8'h5A);
        rchk(A_LIM, 32'h5A);
        wr(A_CTL, 8'hF8);
        rchk(A_CTL, 32'h78);
    endtask : t_regs
    // Gap between matches: (period+1) * 4 * prescale
    task automatic t_prescale;
        int c;
        int div;
        // Count left above the period would wrap through 255 first
        wr(A_CNT, 8'h00);
        wr(A_LIM, 8'h01);
        for (int k = 0; k < 4; k++) begin
            div = (k == 0) ? 1 : (k == 1) ? 4 : 16;
            wr(A_CTL, {6'h01, k[1:0]});
            wait_match(c);
            wait_match(c);
            chk("match_gap", 8 * div, c);
        end
    endtask : t_prescale
    // Postscale n flags after n+1 matches; flag sticky, mask gates irq
    task automatic t_post;
        int m;
        // Stop and clear the flag left set by the prescale runs
        wr(A_CTL, 8'h00);
        wr(A_FLG, 8'h02);
        wr(A_ENA, 8'h02);
        for (int n = 0; n < 16; n++) begin
            wr(A_CNT, 8'h00);
            wr(A_CTL, {1'b0, n[3:0], 3'h4});
            m = 0;
            for (int k = 0; k < 300 && irq !== 1'b1; k++) begin
                @(posedge aclk);
                if (match_to_capture === 1'b1) m++;
            end
            chk("matches", n + 1, m);
            wr(A_CTL, 8'h00);
            wr(A_ENA, 8'h00);
            chk("irq_masked", 32'h0, {31'h0, irq});
            rchk(A_FLG, 32'h02);
            wr(A_FLG, 8'h02);
            rchk(A_FLG, 32'h00);
            wr(A_ENA, 8'h02);
        end
    endtask : t_post
    // Stopped timer holds; control write keeps the count
    task automatic t_stop;
        wr(A_CNT, 8'h33);
        wr(A_CTL, 8'h78);
        repeat (40) @(posedge aclk);
        rchk(A_CNT, 32'h33);
    endtask : t_stop
    task automatic report_and_stop;
        if (n_errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    // Watchdog well beyond the roughly 2000 cycles needed
    initial begin
        #400000;
        n_errors++;
        report_and_stop();
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
        {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
        s_axi_wstrb = 4'hF;
        s_axi_bready = 1'b1;
        n_errors = 0;
        checks_done = 0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_stop();
        t_prescale();
        t_post();
        report_and_stop();
    end
endmodule : pmt_timer_test
